// *** shared/rupl_pkg.sv ***
// Constants and types shared by the remote update page loader.
`default_nettype none
package rupl_pkg;
    localparam int STATUS_W = 5;
    localparam int WDOG_W = 12;
    localparam int PAGE_W = 3;
    localparam int MODE_W = 2;
    // Shift chain: page, watchdog enable, watchdog value, status, current image.
    localparam int CHAIN_W = PAGE_W + 1 + WDOG_W + STATUS_W + 1;
    localparam int POS_APP = 0;
    localparam int POS_STATUS = 1;
    localparam int POS_WDOG = POS_STATUS + STATUS_W;
    localparam int POS_WDEN = POS_WDOG + WDOG_W;
    localparam int POS_PAGE = POS_WDEN + 1;
    localparam logic [PAGE_W-1:0] PAGE_FACTORY = 3'h0;
    localparam logic [PAGE_W-1:0] PAGE_LOCAL_APP = 3'h1;
    localparam logic [STATUS_W-1:0] STATUS_RESET = 5'h00;
    localparam logic [WDOG_W-1:0] WDOG_RESET = 12'h000;
    localparam int ST_CRC = 0;
    localparam int ST_NSTATUS = 1;
    localparam int ST_CORE = 2;
    localparam int ST_EXTREQ = 3;
    localparam int ST_WDOG = 4;
    // Each watchdog value unit counts this many clock cycles.
    localparam int WDOG_TICK_CYC = 16;
    localparam logic [7:0] TICK_RESET = 8'h00;

    typedef enum logic [MODE_W-1:0] {
        RUPL_LOAD = 2'b00,
        RUPL_USER = 2'b01,
        RUPL_FAULT = 2'b10
    } rupl_state_t;
endpackage : rupl_pkg
`default_nettype wire

// *** verilog/rupl_sync.sv ***
// Two flip-flop synchroniser for one level from outside the clock domain.
`default_nettype none
module rupl_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Level in and out
    input wire logic d,
    output logic q
);
    logic meta_r;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_r <= 1'b0;
            q <= 1'b0;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : rupl_sync
`default_nettype wire

// *** verilog/rupl_wdog.sv ***
// User watchdog counter with clear and timeout pulse.
`default_nettype none
module rupl_wdog
    import rupl_pkg::*;
#(
    parameter int TICK = WDOG_TICK_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Control
    input wire logic run,
    input wire logic clear,
    input wire logic [rupl_pkg::WDOG_W-1:0] limit,
    // Timeout
    output logic expired
);
    import rupl_pkg::*;
    logic [7:0] tick_r, tick_nxt;
    logic [WDOG_W-1:0] cnt_r, cnt_nxt;
    logic exp_nxt;
    always_comb
    begin
        tick_nxt = tick_r;
        cnt_nxt = cnt_r;
        exp_nxt = 1'b0;
        if (!run || clear)
        begin
            tick_nxt = TICK_RESET;
            cnt_nxt = '0;
        end
        else if (tick_r == 8'(TICK - 1))
        begin
            tick_nxt = TICK_RESET;
            if (cnt_r >= limit)
            begin
                exp_nxt = 1'b1;
                cnt_nxt = '0;
            end
            else
                cnt_nxt = cnt_r + 1'b1;
        end
        else
            tick_nxt = tick_r + 8'h01;
    end
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            tick_r <= TICK_RESET;
            cnt_r <= WDOG_RESET;
            expired <= 1'b0;
        end
        else
        begin
            tick_r <= tick_nxt;
            cnt_r <= cnt_nxt;
            expired <= exp_nxt;
        end
    end
endmodule : rupl_wdog
`default_nettype wire

// *** verilog/rupl_top.sv ***
// Remote update cell: serial shift chain, page selection, watchdog and fallback.
//
// Notes on behaviour
// - All interface operations happen on the rising clock edge.
// - Shift mode moves chain one bit toward the serial output each edge.
// - Capture/update select chooses reading mode status or writing control registers.
// - Holding watchdog clear high keeps the watchdog timer reset.
// - A rising reconfiguration trigger starts a new configuration cycle.
// - Serial output is the last chain stage, refreshed every edge.
// - Page select is three bits naming the page loaded next.
// - Remote mode power-up loads factory page zero.
// - Error-free application load enters user mode.
// - Failed application load or watchdog expiry reloads the factory image.
// - Local mode power-up loads application page one directly.
// - Local mode load error loads factory image automatically.
// - Five-bit status records reconfiguration cause, cleared at power-on.
// - Twelve-bit watchdog value, cleared at power-on, writable only in factory image.
`default_nettype none
module rupl_top
    import rupl_pkg::*;
#(
    parameter int TICK = rupl_pkg::WDOG_TICK_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Serial interface from core
    input wire logic shift_or_load_select,
    input wire logic capture_or_update_select,
    input wire logic serial_in_from_core,
    output logic serial_out_to_core,
    // Watchdog and reconfiguration
    input wire logic watchdog_clear,
    input wire logic reconfig_trigger,
    // Mode strap and configuration events
    input wire logic remote_local_select,
    input wire logic load_done,
    input wire logic load_error,
    input wire logic crc_error,
    input wire logic ext_status_error,
    input wire logic core_error,
    // Configuration memory and state
    output logic [rupl_pkg::PAGE_W-1:0] page_select_out,
    output logic app_running,
    output logic user_mode
);
    import rupl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin inputs from other domains pass two flip-flops first.
    logic trig_s, rl_s, done_s, lerr_s, crc_s, nst_s, core_s, wclr_s;
    rupl_sync u_s_trig (.clk(clk), .resetn(resetn), .d(reconfig_trigger), .q(trig_s));
    rupl_sync u_s_rl (.clk(clk), .resetn(resetn), .d(remote_local_select), .q(rl_s));
    rupl_sync u_s_done (.clk(clk), .resetn(resetn), .d(load_done), .q(done_s));
    rupl_sync u_s_lerr (.clk(clk), .resetn(resetn), .d(load_error), .q(lerr_s));
    rupl_sync u_s_crc (.clk(clk), .resetn(resetn), .d(crc_error), .q(crc_s));
    rupl_sync u_s_nst (.clk(clk), .resetn(resetn), .d(ext_status_error), .q(nst_s));
    rupl_sync u_s_core (.clk(clk), .resetn(resetn), .d(core_error), .q(core_s));
    rupl_sync u_s_wclr (.clk(clk), .resetn(resetn), .d(watchdog_clear), .q(wclr_s));

    ////////////////////////////////////////////////////////////////////////////
    // Configuration state.
    rupl_state_t state_r, state_nxt;
    logic [CHAIN_W-1:0] chain_r, chain_nxt;
    logic [PAGE_W-1:0] page_r, page_nxt;
    logic [WDOG_W-1:0] wval_r, wval_nxt;
    logic wden_r, wden_nxt;
    logic [STATUS_W-1:0] status_r, status_nxt;
    logic app_r, app_nxt;
    logic trig_d_r;
    logic strap_done_r;
    logic [1:0] strap_arm_r;
    logic sout_r;
    logic wdog_exp;
    logic trig_rise;
    logic [STATUS_W-1:0] cause_load, cause_user;

    assign trig_rise = trig_s && !trig_d_r;

    ////////////////////////////////////////////////////////////////////////////
    // Fault causes are latched on the edge that leaves LOAD or USER.
    // The watchdog timeout is a single-cycle pulse, so it is already gone in FAULT.
    always_comb
    begin
        cause_load = STATUS_RESET;
        cause_load[ST_CRC] = crc_s;
        cause_load[ST_NSTATUS] = nst_s || lerr_s;
        cause_user = STATUS_RESET;
        cause_user[ST_CORE] = core_s;
        cause_user[ST_WDOG] = wdog_exp;
    end

    rupl_wdog #(.TICK(TICK)) u_wdog (
        .clk(clk),
        .resetn(resetn),
        .run(state_r == RUPL_USER && app_r && wden_r),
        .clear(wclr_s),
        .limit(wval_r),
        .expired(wdog_exp)
    );

    always_comb
    begin
        state_nxt = state_r;
        chain_nxt = chain_r;
        page_nxt = page_r;
        wval_nxt = wval_r;
        wden_nxt = wden_r;
        status_nxt = status_r;
        app_nxt = app_r;
        if (shift_or_load_select)
            chain_nxt = {serial_in_from_core, chain_r[CHAIN_W-1:1]};
        else if (capture_or_update_select)
        begin
            chain_nxt = {page_r, wden_r, wval_r, status_r, app_r};
        end
        else if (!app_r)
        begin
            page_nxt = chain_r[POS_PAGE +: PAGE_W];
            wden_nxt = chain_r[POS_WDEN];
            wval_nxt = chain_r[POS_WDOG +: WDOG_W];
        end
        unique case (state_r)
            RUPL_LOAD:
            begin
                if (lerr_s || crc_s || nst_s)
                begin
                    state_nxt = RUPL_FAULT;
                    status_nxt = cause_load;
                end
                else if (done_s)
                    state_nxt = RUPL_USER;
            end
            RUPL_USER:
            begin
                if (core_s || wdog_exp)
                begin
                    state_nxt = RUPL_FAULT;
                    status_nxt = cause_user;
                end
                else if (trig_rise)
                begin
                    state_nxt = RUPL_LOAD;
                    status_nxt = '0;
                    status_nxt[ST_EXTREQ] = 1'b1;
                    app_nxt = (page_r != PAGE_FACTORY);
                end
            end
            RUPL_FAULT:
            begin
                // error fallback, remote and local
                // Local mode falls back to page zero too, as only that page holds the factory image.
                state_nxt = RUPL_LOAD;
                app_nxt = 1'b0;
                page_nxt = PAGE_FACTORY;
            end
            default:
                state_nxt = RUPL_LOAD;
        endcase
        // The strap synchroniser needs two edges, so the strap is taken on the third.
        if (!strap_done_r && strap_arm_r[1])
        begin
            page_nxt = rl_s ? PAGE_FACTORY : PAGE_LOCAL_APP;
            app_nxt = !rl_s;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r <= RUPL_LOAD;
            chain_r <= '0;
            page_r <= PAGE_FACTORY;
            wval_r <= WDOG_RESET;
            wden_r <= 1'b0;
            status_r <= STATUS_RESET;
            app_r <= 1'b0;
            trig_d_r <= 1'b0;
            strap_done_r <= 1'b0;
            strap_arm_r <= 2'h0;
            sout_r <= 1'b0;
            page_select_out <= PAGE_FACTORY;
            app_running <= 1'b0;
            user_mode <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            chain_r <= chain_nxt;
            page_r <= page_nxt;
            wval_r <= wval_nxt;
            wden_r <= wden_nxt;
            status_r <= status_nxt;
            app_r <= app_nxt;
            trig_d_r <= trig_s;
            strap_arm_r <= {strap_arm_r[0], 1'b1};
            strap_done_r <= strap_arm_r[1];
            sout_r <= chain_nxt[0];
            page_select_out <= page_nxt;
            app_running <= app_nxt;
            user_mode <= (state_nxt == RUPL_USER);
        end
    end
    assign serial_out_to_core = sout_r;

    ////////////////////////////////////////////////////////////////////////////
    // The page bus is a pin bus; only the checks below read it back, the logic uses page_r.

    a_shift_moves: assert property (@(posedge clk) disable iff (!resetn)
        shift_or_load_select |=> chain_r[CHAIN_W-1] == $past(serial_in_from_core))
        else $error("shift did not take serial input");
    a_out_last_stage: assert property (@(posedge clk) disable iff (!resetn)
        serial_out_to_core == chain_r[0])
        else $error("serial out not last stage");
    a_capture_status: assert property (@(posedge clk) disable iff (!resetn)
        (!shift_or_load_select && capture_or_update_select) |=> chain_r[POS_STATUS +: STATUS_W] == $past(status_r))
        else $error("capture missed status");
    a_wval_factory_only: assert property (@(posedge clk) disable iff (!resetn)
        $past(app_r) && strap_done_r && $past(strap_done_r) |-> $stable(wval_r))
        else $error("watchdog value written in application");
    a_page_bus: assert property (@(posedge clk) disable iff (!resetn)
        strap_done_r && state_r == RUPL_USER && app_r |=> $stable(page_select_out))
        else $error("page bus moved while application ran");
    a_fault_factory: assert property (@(posedge clk) disable iff (!resetn)
        state_r == RUPL_FAULT && strap_done_r |=> !app_r && state_r == RUPL_LOAD)
        else $error("fault did not reload factory");
    a_wdog_status: assert property (@(posedge clk) disable iff (!resetn)
        state_r == RUPL_USER && wdog_exp |=> ##1 status_r[ST_WDOG])
        else $error("watchdog cause not recorded");
    a_trig_reload: assert property (@(posedge clk) disable iff (!resetn)
        state_r == RUPL_USER && trig_rise && !core_s && !wdog_exp |=> state_r == RUPL_LOAD)
        else $error("trigger did not start configuration");
    a_user_entry: assert property (@(posedge clk) disable iff (!resetn)
        state_r == RUPL_LOAD && done_s && !lerr_s && !crc_s && !nst_s |=> state_r == RUPL_USER)
        else $error("clean load did not enter user mode");

    ////////////////////////////////////////////////////////////////////////////
    // Strap, fallback, watchdog and chain checks.
    a_remote_start: assert property (@(posedge clk) disable iff (!resetn)
        $rose(strap_done_r) && rl_s |-> page_select_out == PAGE_FACTORY && !app_running)
        else $error("remote power-up did not select factory page");
    a_local_start: assert property (@(posedge clk) disable iff (!resetn)
        $rose(strap_done_r) && !rl_s |-> page_select_out == PAGE_LOCAL_APP && app_running)
        else $error("local power-up did not select page one");
    a_fault_page: assert property (@(posedge clk) disable iff (!resetn)
        state_r == RUPL_FAULT && strap_done_r |=> page_select_out == PAGE_FACTORY)
        else $error("fault did not point at factory page");
    a_wdog_held: assert property (@(posedge clk) disable iff (!resetn)
        wclr_s |=> !wdog_exp)
        else $error("watchdog expired while cleared");
    a_idle_watchdog: assert property (@(posedge clk) disable iff (!resetn)
        state_r != RUPL_USER |=> !wdog_exp)
        else $error("watchdog expired outside user mode");
    a_load_error: assert property (@(posedge clk) disable iff (!resetn)
        state_r == RUPL_LOAD && lerr_s |=> state_r == RUPL_FAULT && status_r[ST_NSTATUS])
        else $error("load error did not fault");
    a_ext_request: assert property (@(posedge clk) disable iff (!resetn)
        state_r == RUPL_USER && trig_rise && !core_s && !wdog_exp |=> status_r[ST_EXTREQ] && $onehot(status_r))
        else $error("request cause not recorded");
    a_update_refused: assert property (@(posedge clk) disable iff (!resetn)
        !shift_or_load_select && !capture_or_update_select && app_r |=> $stable(wval_r) && $stable(wden_r))
        else $error("application image changed watchdog setup");
    a_update_writes: assert property (@(posedge clk) disable iff (!resetn)
        strap_done_r && state_r != RUPL_FAULT && !shift_or_load_select && !capture_or_update_select && !app_r
        |=> page_r == $past(chain_r[POS_PAGE +: PAGE_W]))
        else $error("update did not load page");
    a_chain_hold: assert property (@(posedge clk) disable iff (!resetn)
        !shift_or_load_select && !capture_or_update_select |=> $stable(chain_r))
        else $error("chain changed during update");
    a_serial_moves: assert property (@(posedge clk) disable iff (!resetn)
        shift_or_load_select |=> serial_out_to_core == $past(chain_r[1]))
        else $error("serial out did not advance");

    c_shift_run: cover property (@(posedge clk) disable iff (!resetn) shift_or_load_select [*8]);
    c_user_mode: cover property (@(posedge clk) disable iff (!resetn) state_r == RUPL_USER);
    c_wdog_fault: cover property (@(posedge clk) disable iff (!resetn) wdog_exp);
    c_load_error: cover property (@(posedge clk) disable iff (!resetn) state_r == RUPL_LOAD && lerr_s);
    c_update: cover property (@(posedge clk) disable iff (!resetn)
        !shift_or_load_select && !capture_or_update_select && !app_r);
endmodule : rupl_top
`default_nettype wire

// *** tb/rupl_cfg_mem.sv ***
// Behavioural configuration memory that answers page loads.
`default_nettype none
module rupl_cfg_mem
    import rupl_pkg::*;
#(
    parameter int DLY = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Page request and state
    input wire logic [rupl_pkg::PAGE_W-1:0] page_select_out,
    input wire logic user_mode,
    // Page that fails to load
    input wire logic [rupl_pkg::PAGE_W-1:0] bad_page,
    // Load result
    output logic load_done,
    output logic load_error
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    ////////////////////////////////////////
    // page pins only
    // The result stands six cycles so the two flop synchroniser sees it.
    always @(negedge clk or negedge resetn)
    begin
        if (!resetn || user_mode)
        begin
            cnt <= 0;
            load_done <= 1'b0;
            load_error <= 1'b0;
        end
        else if (cnt == DLY + 6)
        begin
            cnt <= 0;
            load_done <= 1'b0;
            load_error <= 1'b0;
        end
        else
        begin
            cnt <= cnt + 1;
            if (cnt == DLY)
            begin
                load_done <= page_select_out !== bad_page;
                load_error <= page_select_out === bad_page;
            end
        end
    end
endmodule : rupl_cfg_mem
`default_nettype wire

// *** tb/test_remote_update_page_loader.sv ***
// Testbench for the remote update page loader.
`default_nettype none
module test_remote_update_page_loader
    import rupl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic resetn;
    logic shift_or_load_select;
    logic capture_or_update_select;
    logic serial_in_from_core;
    logic serial_out_to_core;
    logic watchdog_clear;
    logic reconfig_trigger;
    logic remote_local_select;
    logic load_done;
    logic load_error;
    logic crc_error;
    logic ext_status_error;
    logic core_error;
    logic [PAGE_W-1:0] page_select_out;
    logic [PAGE_W-1:0] bad_page;
    logic app_running;
    logic user_mode;
    logic [CHAIN_W-1:0] r;
    int bad_count;
    int n_checks;
    always #2 clk = ~clk;
    ////////////////////////////////////////
    // single cell
    rupl_top #(.TICK(2)) uut (.clk, .resetn, .shift_or_load_select, .capture_or_update_select,
        .serial_in_from_core, .serial_out_to_core, .watchdog_clear, .reconfig_trigger,
        .remote_local_select, .load_done, .load_error, .crc_error, .ext_status_error,
        .core_error, .page_select_out, .app_running, .user_mode);
    rupl_cfg_mem #(.DLY(8)) mem (.clk, .resetn, .page_select_out, .user_mode, .bad_page,
        .load_done, .load_error);
    task test_done;
        if (bad_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task xfer(input logic [CHAIN_W-1:0] w, output logic [CHAIN_W-1:0] o);
        for (int i = 0; i < CHAIN_W; i++)
        begin
            @(negedge clk);
            o[i] = serial_out_to_core;
            serial_in_from_core = w[i];
            shift_or_load_select = 1'b1;
        end
    endtask : xfer
    task read_chain(output logic [CHAIN_W-1:0] o);
        @(negedge clk);
        shift_or_load_select = 1'b0;
        xfer('0, o);
        @(negedge clk);
        shift_or_load_select = 1'b0;
    endtask : read_chain
    // The second pass returns the first word, which proves the chain length and order.
    task write_chain(input logic [CHAIN_W-1:0] w);
        logic [CHAIN_W-1:0] d;
        xfer(w, d);
        xfer(w, d);
        chk(d, w);
        @(negedge clk);
        shift_or_load_select = 1'b0;
        capture_or_update_select = 1'b0;
        @(negedge clk);
        capture_or_update_select = 1'b1;
    endtask : write_chain
    task wait_um(input logic v);
        for (int i = 0; i < 400; i++)
        begin
            if (user_mode === v)
                return;
            @(negedge clk);
        end
        chk(user_mode, v);
        test_done();
    endtask : wait_um
    task trigger;
        reconfig_trigger = 1'b1;
        cyc(4);
        reconfig_trigger = 1'b0;
        wait_um(1'b0);
        wait_um(1'b1);
    endtask : trigger
    ////////////////////////////////////////
    initial
    begin
        resetn = 1'b0;
        shift_or_load_select = 1'b0;
        capture_or_update_select = 1'b1;
        serial_in_from_core = 1'b0;
        watchdog_clear = 1'b0;
        reconfig_trigger = 1'b0;
        remote_local_select = 1'b1;
        crc_error = 1'b0;
        ext_status_error = 1'b0;
        core_error = 1'b0;
        bad_page = 3'h7;
        bad_count = 0;
        n_checks = 0;
        cyc(20);
        resetn = 1'b1;
        cyc(3);
        chk(page_select_out, PAGE_FACTORY);
        wait_um(1'b1);
        chk(app_running, 1'b0);
        read_chain(r);
        chk(r[POS_STATUS+:STATUS_W], STATUS_RESET);
        chk(r[POS_WDOG+:WDOG_W], WDOG_RESET);
        chk(r[POS_APP], 1'b0);
        write_chain({3'h2, 1'b1, 12'h001, 5'h00, 1'b0});
        cyc(2);
        chk(page_select_out, 3'h2);
        watchdog_clear = 1'b1;
        trigger();
        chk(app_running, 1'b1);
        read_chain(r);
        chk(r[POS_STATUS+:STATUS_W], 5'h08);
        // An application image may not move the page pointer.
        write_chain({3'h5, 1'b1, 12'h001, 5'h00, 1'b0});
        cyc(40);
        chk(user_mode, 1'b1);
        chk(page_select_out, 3'h2);
        watchdog_clear = 1'b0;
        wait_um(1'b0);
        wait_um(1'b1);
        chk(page_select_out, PAGE_FACTORY);
        read_chain(r);
        chk(r[POS_STATUS+:STATUS_W], 5'h10);
        write_chain({3'h3, 1'b0, 12'h000, 5'h00, 1'b0});
        bad_page = 3'h3;
        trigger();
        chk(page_select_out, PAGE_FACTORY);
        read_chain(r);
        chk(r[POS_STATUS+:STATUS_W], 5'h02);
        resetn = 1'b0;
        remote_local_select = 1'b0;
        bad_page = 3'h1;
        cyc(20);
        resetn = 1'b1;
        cyc(3);
        chk(page_select_out, PAGE_LOCAL_APP);
        wait_um(1'b1);
        chk(app_running, 1'b0);
        chk(page_select_out, PAGE_FACTORY);
        chk(user_mode, 1'b1);
        read_chain(r);
        chk(r[POS_STATUS+:STATUS_W], 5'h02);
        test_done();
    end
endmodule : test_remote_update_page_loader
`default_nettype wire
